// ---- src/host_port_pkg.sv ----
// Shared constants and types for the host bus port
package host_port_pkg;

  // Register select and data widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Layout of the synchronised pin vector
  localparam int SY_CS    = 0;
  localparam int SY_RD    = 1;
  localparam int SY_WR    = 2;
  localparam int SY_ADDR  = 3;
  localparam int SY_DATA  = 6;
  localparam int SY_STYLE = 14;
  localparam int SY_PAR   = 15;
  localparam int SY_RX    = 16;
  localparam int SYNC_W   = 17;

  // Pins idle high, so the synchroniser resets to all ones
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h1FFFF;

  // Modem control register: select code, field positions, reset value
  localparam logic [ADDR_W-1:0] MCR_ADDR     = 3'h4;
  localparam int                MCR_IRQ_EN   = 3;
  localparam int                MCR_PATH_SEL = 6;
  localparam logic [DATA_W-1:0] MCR_RESET    = 8'h00;

  // Edges to wait after reset before the straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Transfer phase of the host port
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_READ  = 3'b010,
    PH_WRITE = 3'b100
  } phase_t;

endpackage

// ---- src/host_sync_if.sv ----
// Carrier between the pin synchroniser and the host port logic
`timescale 1ns/1ps
interface host_sync_if;
  import host_port_pkg::*;

  logic [SYNC_W-1:0] raw;   // Pin levels as they arrive
  logic [SYNC_W-1:0] sync;  // Same levels after two flops

  modport pins (output raw, input sync);
  modport sync_side (input raw, output sync);
endinterface

// ---- src/pin_sync.sv ----
// Two-flop synchroniser for every asynchronous host pin
`timescale 1ns/1ps
module pin_sync (
  input  logic     clk_i,     // System clock
  input  logic     resetn_i,  // Asynchronous reset, active low
  host_sync_if.sync_side bus  // Raw pins in, clean levels out
);
  import host_port_pkg::*;

  logic [SYNC_W-1:0] meta_r;

  // One chain per bit; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_r[g]   <= SYNC_RST[g];
          bus.sync[g] <= SYNC_RST[g];
        end else begin
          meta_r[g]   <= bus.raw[g];
          bus.sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule

// ---- src/uart_host_bus_port.sv ----
// Host parallel bus port of the UART: decode, strobes, interrupt and status pins
`timescale 1ns/1ps
module uart_host_bus_port (
  input  logic                              clk_i,             // 100 MHz system clock
  input  logic                              resetn_i,          // Asynchronous reset, active low
  input  logic                              chip_sel_n_i,      // Chip select pin, active low
  input  logic                              read_strobe_n_i,   // Read strobe pin, active low
  input  logic                              write_strobe_n_i,  // Write strobe or direction pin
  input  logic [host_port_pkg::ADDR_W-1:0]  reg_select_lines_i,// Register select pins
  input  logic [host_port_pkg::DATA_W-1:0]  host_data_bus_i,   // Data bus pin levels
  output logic [host_port_pkg::DATA_W-1:0]  host_data_bus_o,   // Data bus drive value
  output logic                              host_data_bus_oe_o,// Data bus output enable
  input  logic                              bus_style_i,       // Strap: high selects separate strobes
  input  logic                              parallel_mode_i,   // Strap: high selects parallel host
  output logic                              irq_o,             // Interrupt pin drive value
  output logic                              irq_oe_o,          // Interrupt pin output enable
  output logic                              tx_space_flag_n_o, // Transmitter ready, active low
  output logic                              rx_data_flag_n_o,  // Receiver ready, active low
  output logic                              serial_tx_o,       // Serial transmit pin
  input  logic                              serial_rx_i,       // Serial receive pin
  output logic [host_port_pkg::ADDR_W-1:0]  reg_addr_o,        // Register select to the UART core
  output logic [host_port_pkg::DATA_W-1:0]  reg_wdata_o,       // Write byte to the UART core
  output logic                              reg_wr_o,          // Write pulse to the UART core
  output logic                              reg_rd_o,          // Read pulse to the UART core
  input  logic [host_port_pkg::DATA_W-1:0]  reg_rdata_i,       // Read byte, valid with reg_rd_o
  input  logic                              cpu_wr_i,          // Embedded processor write request
  input  logic                              cpu_rd_i,          // Embedded processor read request
  input  logic [host_port_pkg::ADDR_W-1:0]  cpu_addr_i,        // Embedded processor register select
  input  logic [host_port_pkg::DATA_W-1:0]  cpu_wdata_i,       // Embedded processor write byte
  input  logic                              irq_req_i,         // Interrupt request from the core
  input  logic                              tx_space_i,        // Transmit FIFO or holding has room
  input  logic                              rx_avail_i,        // Receive FIFO or holding has data
  input  logic                              core_tx_i,         // Serial bit from the transmitter
  output logic                              core_rx_o          // Serial bit to the receiver
);
  import host_port_pkg::*;

  host_sync_if sy ();

  logic                cs_n_s, rd_n_s, wr_n_s, style_s, par_s, rx_s;
  logic [ADDR_W-1:0]   addr_s;
  logic [DATA_W-1:0]   data_s;
  logic                cs_n_q, rd_n_q, wr_n_q;
  logic [1:0]          settle_r;
  logic                strap_done_r, strobe_mode_r, par_mode_r;
  phase_t              phase_r, phase_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic                host_rd, host_wr;
  logic [DATA_W-1:0]   mcr_r;
  logic [DATA_W-1:0]   rdata_r;

  // Every pin passes two flops before any logic looks at it
  assign sy.raw = {serial_rx_i, parallel_mode_i, bus_style_i, host_data_bus_i,
                   reg_select_lines_i, write_strobe_n_i, read_strobe_n_i, chip_sel_n_i};

  pin_sync u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .bus      (sy.sync_side)
  );

  assign cs_n_s  = sy.sync[SY_CS];
  assign rd_n_s  = sy.sync[SY_RD];
  assign wr_n_s  = sy.sync[SY_WR];
  assign addr_s  = sy.sync[SY_ADDR +: ADDR_W];
  assign data_s  = sy.sync[SY_DATA +: DATA_W];
  assign style_s = sy.sync[SY_STYLE];
  assign par_s   = sy.sync[SY_PAR];
  assign rx_s    = sy.sync[SY_RX];

  // Previous strobe levels for edge detection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n_s;
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
    end
  end

  // Straps are caught once the synchroniser has flushed reset values
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_r      <= 2'h0;
      strap_done_r  <= 1'b0;
      strobe_mode_r <= 1'b1;
      par_mode_r    <= 1'b0;
    end else if (!strap_done_r) begin
      if (settle_r == STRAP_SETTLE) begin
        strap_done_r  <= 1'b1;
        strobe_mode_r <= style_s;
        par_mode_r    <= par_s;
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  // Host transfer sequencing for both bus styles
  always_comb begin
    phase_nxt = phase_r;
    addr_nxt  = addr_r;
    host_rd   = 1'b0;
    host_wr   = 1'b0;
    unique case (phase_r)
      PH_IDLE: begin
        if (strap_done_r && par_mode_r && !cs_n_s) begin
          if (strobe_mode_r) begin
            // Direction pin doubles as write strobe only here; read strobe ignored otherwise
            if (rd_n_q && !rd_n_s) begin
              phase_nxt = PH_READ;
              addr_nxt  = addr_s;
              host_rd   = 1'b1;
            end else if (wr_n_q && !wr_n_s) begin
              phase_nxt = PH_WRITE;
              addr_nxt  = addr_s;
            end
          end else if (cs_n_q) begin
            addr_nxt = addr_s;
            if (wr_n_s) begin
              phase_nxt = PH_READ;
              host_rd   = 1'b1;
            end else begin
              phase_nxt = PH_WRITE;
            end
          end
        end
      end
      PH_READ: begin
        if (cs_n_s || (strobe_mode_r && rd_n_s)) begin
          phase_nxt = PH_IDLE;
        end
      end
      PH_WRITE: begin
        if (strobe_mode_r) begin
          // Chip select dropped before the strobe rose: abandon the write
          if (cs_n_s) begin
            phase_nxt = PH_IDLE;
          end else if (wr_n_s) begin
            phase_nxt = PH_IDLE;
            host_wr   = 1'b1;
          end
        end else if (cs_n_s) begin
          // Byte is taken as chip select closes the cycle
          phase_nxt = PH_IDLE;
          host_wr   = 1'b1;
        end
      end
      default: phase_nxt = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= PH_IDLE;
      addr_r  <= '0;
    end else begin
      phase_r <= phase_nxt;
      addr_r  <= addr_nxt;
    end
  end

  // Register access toward the core; the processor is locked out in parallel mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_addr_o  <= '0;
      reg_wdata_o <= '0;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
    end else if (par_mode_r || !strap_done_r) begin
      reg_addr_o  <= addr_nxt;
      reg_wdata_o <= data_s;
      reg_wr_o    <= host_wr;
      reg_rd_o    <= host_rd;
    end else begin
      reg_addr_o  <= cpu_addr_i;
      reg_wdata_o <= cpu_wdata_i;
      reg_wr_o    <= cpu_wr_i;
      reg_rd_o    <= cpu_rd_i && !cpu_wr_i;
    end
  end

  // Shadow of the modem control register, snooped from committed writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcr_r <= MCR_RESET;
    end else if (reg_wr_o && reg_addr_o == MCR_ADDR) begin
      mcr_r <= reg_wdata_o;
    end
  end

  // Read data is captured the cycle after the core is asked
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= '0;
    end else if (reg_rd_o) begin
      rdata_r <= reg_rdata_i;
    end
  end

  // Bus is driven only inside a selected read cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_data_bus_oe_o <= 1'b0;
    end else begin
      host_data_bus_oe_o <= (phase_nxt == PH_READ);
    end
  end
  assign host_data_bus_o = rdata_r;

  // Interrupt pin: push-pull high or open-drain low, gated by the enable bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o    <= 1'b0;
      irq_oe_o <= 1'b0;
    end else if (strobe_mode_r) begin
      irq_o    <= irq_req_i;
      irq_oe_o <= mcr_r[MCR_IRQ_EN];
    end else begin
      irq_o    <= 1'b0;
      irq_oe_o <= mcr_r[MCR_IRQ_EN] && irq_req_i;
    end
  end

  // Ready flags; a flop here keeps pin timing independent of core paths
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_space_flag_n_o <= 1'b1;
      rx_data_flag_n_o  <= 1'b1;
    end else begin
      tx_space_flag_n_o <= !tx_space_i;
      rx_data_flag_n_o  <= !rx_avail_i;
    end
  end

  // Serial pins; idle high so the far end sees no false start bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_tx_o <= 1'b1;
      core_rx_o   <= 1'b1;
    end else begin
      serial_tx_o <= mcr_r[MCR_PATH_SEL] ? 1'b1 : core_tx_i;
      core_rx_o   <= mcr_r[MCR_PATH_SEL] ? 1'b1 : rx_s;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_oe_needs_cs;
    host_data_bus_oe_o |-> $past(!cs_n_s);
  endproperty
  a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("data bus driven without chip select");

  property p_rd_addr;
    reg_rd_o && par_mode_r && $past(strap_done_r) |-> reg_addr_o == $past(addr_s);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read targets wrong register");

  property p_strobe_read;
    reg_rd_o && par_mode_r && strobe_mode_r |-> $past(rd_n_q && !rd_n_s && !cs_n_s);
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("read without strobe fall");

  property p_strobe_write;
    reg_wr_o && par_mode_r && strobe_mode_r |-> $past(!wr_n_q && wr_n_s) && reg_wdata_o == $past(data_s);
  endproperty
  a_strobe_write: assert property (p_strobe_write) else $error("write not on strobe rise");

  property p_dir_read;
    reg_rd_o && par_mode_r && !strobe_mode_r |-> $past(wr_n_s && !cs_n_s);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read with line low");

  property p_cpu_locked;
    par_mode_r && reg_wr_o |-> $past(host_wr);
  endproperty
  a_cpu_locked: assert property (p_cpu_locked) else $error("processor write in parallel mode");

  property p_irq_enable;
    irq_oe_o |-> $past(mcr_r[MCR_IRQ_EN]);
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt driven while disabled");

  property p_irq_open_drain;
    !strobe_mode_r && $past(!strobe_mode_r) && irq_oe_o |-> !irq_o && $past(irq_req_i);
  endproperty
  a_irq_open_drain: assert property (p_irq_open_drain) else $error("open-drain interrupt misdriven");

  property p_irq_high;
    strobe_mode_r && $past(strobe_mode_r) && irq_oe_o |-> irq_o == $past(irq_req_i);
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("interrupt level wrong");

  property p_tx_idle;
    $past(mcr_r[MCR_PATH_SEL]) |-> serial_tx_o && core_rx_o;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("serial pins active with path bit set");

  property p_ready_flags;
    tx_space_flag_n_o != $past(tx_space_i) && rx_data_flag_n_o != $past(rx_avail_i);
  endproperty
  a_ready_flags: assert property (p_ready_flags) else $error("ready flags do not follow core");

  c_strobe_read: cover property (reg_rd_o && par_mode_r && strobe_mode_r ##[1:8] host_data_bus_oe_o);
  c_strobe_write: cover property (reg_wr_o && par_mode_r && strobe_mode_r);
  c_dir_write: cover property (reg_wr_o && par_mode_r && !strobe_mode_r);
  c_mcr_write: cover property (reg_wr_o && reg_addr_o == MCR_ADDR);

endmodule

// ---- test/host_cpu_model.sv ----
// Behavioural host processor driving the parallel bus pins
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic       clk_i,    // Bench clock
  input  wire logic       style_i,  // High: separate strobes
  input  wire logic [7:0] bus_i,    // Resolved data bus level
  output logic            cs_n_o,   // Chip select, active low
  output logic            rd_n_o,   // Read strobe, active low
  output logic            wr_n_o,   // Write strobe or direction
  output logic [2:0]      sel_o,    // Register select
  output logic [7:0]      d_o,      // Write byte
  output logic            d_oe_o    // High while driving data
);
  // Idle pins; read strobe stays high in direction-line mode
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o  = 3'h0;
    d_o    = 8'h00;
    d_oe_o = 1'b0;
  end

  // One byte transfer; strobes held well past the three-clock minimum
  task automatic xfer(input logic wr, input logic sel, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_i);
    sel_o  = a;
    d_o    = d;
    d_oe_o = wr;
    if (!style_i)
      wr_n_o = ~wr;
    repeat (3) @(negedge clk_i);
    cs_n_o = ~sel;
    repeat (3) @(negedge clk_i);
    if (style_i && wr)
      wr_n_o = 1'b0;
    if (style_i && !wr)
      rd_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    // Byte taken just before the strobe rises
    q = bus_i;
    if (style_i) begin
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
    end
    cs_n_o = 1'b1;
    // Data held after chip select rises so a direction-line write sees it
    repeat (4) @(negedge clk_i);
    d_oe_o = 1'b0;
    wr_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

// ---- test/uart_host_bus_port_test.sv ----
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module uart_host_bus_port_test;
  import host_port_pkg::*;
  logic clk_i, resetn_i, chip_sel_n_i, read_strobe_n_i, write_strobe_n_i, bus_style_i, parallel_mode_i;
  logic [2:0] reg_select_lines_i, reg_addr_o, cpu_addr_i;
  logic [7:0] host_data_bus_i, host_data_bus_o, reg_wdata_o, reg_rdata_i, cpu_wdata_i, h_d, q, last_w;
  logic host_data_bus_oe_o, irq_o, irq_oe_o, tx_space_flag_n_o, rx_data_flag_n_o, serial_tx_o, serial_rx_i;
  logic reg_wr_o, reg_rd_o, cpu_wr_i, cpu_rd_i, irq_req_i, tx_space_i, rx_avail_i, core_tx_i, core_rx_o;
  logic h_oe;
  // Idle pattern toggler; only the clocked process below drives it
  logic flip = 1'b0;
  logic [2:0] last_a;
  int err_count, tests_run, wr_cnt, rd_cnt, w0, r0;

  uart_host_bus_port DUT (.clk_i, .resetn_i, .chip_sel_n_i, .read_strobe_n_i, .write_strobe_n_i,
    .reg_select_lines_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o, .bus_style_i,
    .parallel_mode_i, .irq_o, .irq_oe_o, .tx_space_flag_n_o, .rx_data_flag_n_o, .serial_tx_o,
    .serial_rx_i, .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i, .cpu_wr_i, .cpu_rd_i,
    .cpu_addr_i, .cpu_wdata_i, .irq_req_i, .tx_space_i, .rx_avail_i, .core_tx_i, .core_rx_o);

  host_cpu_model host (.clk_i, .style_i(bus_style_i), .bus_i(host_data_bus_i), .cs_n_o(chip_sel_n_i),
    .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i), .sel_o(reg_select_lines_i), .d_o(h_d),
    .d_oe_o(h_oe));

  // Undriven bus shows a changing pattern so stale data cannot pass
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : (h_oe ? h_d : {4{flip, ~flip}});
  // Core answers each register with a byte tied to its select code
  assign reg_rdata_i = {reg_addr_o, 5'h0A};

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Count core pulses and keep the last write
  always @(posedge clk_i) begin
    flip <= ~flip;
    if (reg_wr_o === 1'b1) begin
      wr_cnt++;
      last_a = reg_addr_o;
      last_w = reg_wdata_o;
    end
    if (reg_rd_o === 1'b1)
      rd_cnt++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Reset with given straps; serial line idles high as the far end must
  task automatic do_reset(input logic style, input logic par);
    @(negedge clk_i);
    resetn_i = 1'b0;
    bus_style_i = style;
    parallel_mode_i = par;
    serial_rx_i = 1'b1;
    core_tx_i = 1'b0;
    wait_n(8);
    check(serial_tx_o, 1'b1, "tx in reset");
    check(irq_oe_o, 1'b0, "irq off at power-up");
    check(host_data_bus_oe_o, 1'b0, "bus idle in reset");
    resetn_i = 1'b1;
    core_tx_i = 1'b1;
    wait_n(8);
  endtask

  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    w0 = wr_cnt;
    host.xfer(1'b1, 1'b1, a, d, q);
    check(8'(wr_cnt - w0), 8'h01, "one write pulse");
    check({5'h0, last_a}, {5'h0, a}, "write select");
    check(last_w, d, "write byte");
  endtask

  task automatic host_rd(input logic [2:0] a);
    r0 = rd_cnt;
    host.xfer(1'b0, 1'b1, a, 8'h00, q);
    check(8'(rd_cnt - r0), 8'h01, "one read pulse");
    check(q, {a, 5'h0A}, "read byte");
    check(host_data_bus_oe_o, 1'b0, "bus released");
  endtask

  // Every select code written, then read for its core byte, in strobe mode
  task automatic t_strobe();
    for (int a = 0; a < 8; a++) begin
      host_wr(3'(a), 8'hA0 | 8'(a));
      host_rd(3'(a));
    end
    $display("test strobe done");
  endtask

  // Chip select high and processor requests in parallel mode are refused
  task automatic t_refuse();
    w0 = wr_cnt;
    r0 = rd_cnt;
    host.xfer(1'b1, 1'b0, 3'h3, 8'h55, q);
    host.xfer(1'b0, 1'b0, 3'h3, 8'h00, q);
    @(negedge clk_i);
    cpu_wr_i = 1'b1;
    cpu_addr_i = 3'h5;
    @(negedge clk_i);
    cpu_wr_i = 1'b0;
    cpu_rd_i = 1'b1;
    @(negedge clk_i);
    cpu_rd_i = 1'b0;
    wait_n(4);
    check(8'(wr_cnt - w0), 8'h00, "no write");
    check(8'(rd_cnt - r0), 8'h00, "no read");
    $display("test refuse done");
  endtask

  // Interrupt enable bit and serial path bit in strobe mode
  task automatic t_mcr();
    host_wr(MCR_ADDR, 8'h08);
    irq_req_i = 1'b1;
    wait_n(2);
    check({irq_oe_o, irq_o}, 2'b11, "irq high");
    irq_req_i = 1'b0;
    wait_n(2);
    check({irq_oe_o, irq_o}, 2'b10, "irq low");
    host_wr(MCR_ADDR, 8'h00);
    check(irq_oe_o, 1'b0, "irq disabled");
    core_tx_i = 1'b0;
    serial_rx_i = 1'b0;
    wait_n(4);
    check({serial_tx_o, core_rx_o}, 2'b00, "serial live");
    host_wr(MCR_ADDR, 8'h40);
    check({serial_tx_o, core_rx_o}, 2'b11, "serial off");
    core_tx_i = 1'b1;
    serial_rx_i = 1'b1;
    host_wr(MCR_ADDR, 8'h00);
    check(serial_tx_o, 1'b1, "tx idle high");
    $display("test mcr done");
  endtask

  task automatic t_flags();
    tx_space_i = 1'b1;
    rx_avail_i = 1'b1;
    wait_n(2);
    check({tx_space_flag_n_o, rx_data_flag_n_o}, 2'b00, "flags active");
    tx_space_i = 1'b0;
    wait_n(2);
    check({tx_space_flag_n_o, rx_data_flag_n_o}, 2'b10, "flags split");
    rx_avail_i = 1'b0;
    $display("test flags done");
  endtask

  // Direction-line mode transfers and open-drain interrupt
  task automatic t_dir();
    do_reset(1'b0, 1'b1);
    host_wr(3'h2, 8'h3C);
    host_rd(3'h6);
    host_wr(MCR_ADDR, 8'h08);
    irq_req_i = 1'b1;
    wait_n(2);
    check({irq_oe_o, irq_o}, 2'b10, "irq pulls low");
    irq_req_i = 1'b0;
    wait_n(2);
    check(irq_oe_o, 1'b0, "irq released");
    $display("test dir done");
  endtask

  // Serial strap: host ignored, processor reaches the core
  task automatic t_cpu();
    do_reset(1'b1, 1'b0);
    w0 = wr_cnt;
    host.xfer(1'b1, 1'b1, 3'h1, 8'h77, q);
    check(8'(wr_cnt - w0), 8'h00, "host locked out");
    @(negedge clk_i);
    cpu_addr_i = 3'h5;
    cpu_wdata_i = 8'hC3;
    cpu_wr_i = 1'b1;
    @(negedge clk_i);
    cpu_wr_i = 1'b0;
    wait_n(3);
    check(8'(wr_cnt - w0), 8'h01, "cpu write");
    check({last_a, 5'h0}, {3'h5, 5'h0}, "cpu select");
    check(last_w, 8'hC3, "cpu byte");
    // Processor read path; a write asked in the same cycle wins over the read
    w0 = wr_cnt;
    r0 = rd_cnt;
    @(negedge clk_i);
    cpu_wr_i = 1'b1;
    cpu_rd_i = 1'b1;
    @(negedge clk_i);
    cpu_wr_i = 1'b0;
    @(negedge clk_i);
    cpu_rd_i = 1'b0;
    wait_n(3);
    check(8'(wr_cnt - w0), 8'h01, "cpu write wins");
    check(8'(rd_cnt - r0), 8'h01, "cpu read");
    $display("test cpu done");
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {err_count, tests_run} = '0;
    {resetn_i, cpu_wr_i, cpu_rd_i, irq_req_i, tx_space_i, rx_avail_i} = '0;
    {bus_style_i, parallel_mode_i, serial_rx_i, core_tx_i} = 4'hF;
    cpu_addr_i = 3'h0;
    cpu_wdata_i = 8'h00;
    do_reset(1'b1, 1'b1);
    t_strobe();
    t_refuse();
    t_mcr();
    t_flags();
    t_dir();
    t_cpu();
    results();
  end
endmodule
